// ==== include/aer_params.svh ====
// Constants for the error reporting register bank: offsets, fields, reset values.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
`ifndef AER_PARAMS_SVH
`define AER_PARAMS_SVH
`define AER_OFF_UNC_STATUS   12'h104
`define AER_OFF_UNC_MASK     12'h108
`define AER_OFF_UNC_SEV      12'h10C
`define AER_OFF_COR_STATUS   12'h110
`define AER_OFF_COR_MASK     12'h114
`define AER_OFF_CAP_CTRL     12'h118
`define AER_OFF_HDR_LOG0     12'h11C
`define AER_OFF_HDR_LOG3     12'h128
`define AER_OFF_IRQ_STATUS   12'h130
`define AER_OFF_IRQ_MASK     12'h134
`define AER_UNC_IMPL         32'h001FF011
`define AER_SEV_RESET        32'h00062011
`define AER_COR_IMPL         32'h000011C1
`define AER_CAP_GEN_CAP      5
`define AER_CAP_GEN_EN       6
`define AER_CAP_CHK_CAP      7
`define AER_CAP_CHK_EN       8
`define AER_IRQ_BITS         2
`endif

// ==== include/aer_pkg.sv ====
// Types shared by the error reporting register bank.
// Assumes the constants header is included by users of these types.
package aer_pkg;
	// Bus data phase state of the slave.
	typedef enum logic [0:0] {
		AER_IDLE,
		AER_DATA
	} aer_phase_e;
	// Word of register storage.
	typedef logic [31:0] aer_word_t;
endpackage

// ==== rtl/aer_first_ptr.sv ====
// First error pointer: lowest newly logged uncorrectable position.
// Assumes the caller already gated events by mask and implemented bits.
`timescale 1ns/1ps
module aer_first_ptr (
	// Qualified uncorrectable events.
	input  wire logic [31:0] events,
	// Encoded position and whether any was found.
	output logic      [4:0]  position,
	output logic             found
);
	// Priority encoder from bit 0 upward so simultaneous errors pick one.
	always_comb begin
		position = 5'h00;
		found    = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (events[i]) begin
				position = 5'(i);
				found    = 1'b1;
			end
		end
	end
endmodule

// ==== rtl/aer_regs.sv ====
// Advanced error reporting register bank with AHB-Lite slave and interrupt.
// Assumes error events are single-cycle pulses synchronous to hclk.
// Assumes the header of the failing packet stands on hdr_in in the event cycle.
// Assumes hot_reset is a synchronous level from logic on the same clock.
// The slave never inserts wait states, so hreadyout is tied high.
// A limitation: only one header is kept, so headers of later errors are not logged
// until software clears the status bit that the first error pointer names.
// Summary of operation
// - severity bit zero nonfatal, one fatal
// - bits 0,4,13,17,18 reset fatal
// - receiver error sets correctable bit 0
// - bad packet sets correctable bit 6
// - bad link packet sets bit 7
// - replay counter rollover sets bit 8
// - replay timeout sets bit 12
// - correctable mask blocks message and interrupt, not status logging
// - first error pointer holds first position
// - check and generate capable read one
// - bit 6 enables CRC generation
// - bit 8 enables CRC checking
// - four header words captured, big endian
// - uncorrectable status bits sticky write-one-clear
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "aer_params.svh"
module aer_regs (
	// Clock and resets.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hot_reset,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Error events from the link and transaction layers.
	input  wire logic [31:0] unc_event,
	input  wire logic [31:0] cor_event,
	input  wire logic [127:0] hdr_in,
	// Controls and messages toward the link.
	output logic             ecrc_gen_en,
	output logic             ecrc_chk_en,
	output logic             msg_cor,
	output logic             msg_nonfatal,
	output logic             msg_fatal,
	output logic             irq
);
	////////////////////////////////////////////////////////////////////////////
	// Register state, one struct registered by one process.
	typedef struct packed {
		aer_pkg::aer_phase_e phase;
		logic                wr;
		logic [11:0]         addr;
		logic [31:0]         rdata;
		logic [31:0]         unc_sts;
		logic [31:0]         unc_msk;
		logic [31:0]         sev;
		logic [31:0]         cor_sts;
		logic [31:0]         cor_msk;
		logic [4:0]          fptr;
		logic                fptr_valid;
		logic                gen_en;
		logic                chk_en;
		logic [127:0]        hdr;
		logic [1:0]          irq_sts;
		logic [1:0]          irq_msk;
		logic                m_cor;
		logic                m_nf;
		logic                m_f;
		logic                irq;
	} aer_state_s;

	aer_state_s st_ff;    // Present state.
	aer_state_s nxt_st;   // Next state.
	logic [31:0] unc_log; // Unmasked uncorrectable events that get logged.
	logic [4:0]  enc_pos; // Encoded first position.
	logic        enc_hit; // Any unmasked uncorrectable event.

	// Byte-address decode and masking to implemented bits.
	function automatic logic [31:0] read_reg(input aer_state_s s, input logic [11:0] a);
		logic [31:0] r;
		r = 32'h00000000;
		unique case (a)
			`AER_OFF_UNC_STATUS: r = s.unc_sts;
			`AER_OFF_UNC_MASK:   r = s.unc_msk;
			`AER_OFF_UNC_SEV:    r = s.sev;
			`AER_OFF_COR_STATUS: r = s.cor_sts;
			`AER_OFF_COR_MASK:   r = s.cor_msk;
			`AER_OFF_CAP_CTRL: begin
				r[4:0] = s.fptr;
				r[`AER_CAP_GEN_CAP] = 1'b1;
				r[`AER_CAP_GEN_EN]  = s.gen_en;
				r[`AER_CAP_CHK_CAP] = 1'b1;
				r[`AER_CAP_CHK_EN]  = s.chk_en;
			end
			12'h11C: r = s.hdr[127:96];
			12'h120: r = s.hdr[95:64];
			12'h124: r = s.hdr[63:32];
			`AER_OFF_HDR_LOG3:   r = s.hdr[31:0];
			`AER_OFF_IRQ_STATUS: r = {30'h00000000, s.irq_sts};
			`AER_OFF_IRQ_MASK:   r = {30'h00000000, s.irq_msk};
			default:             r = 32'h00000000;
		endcase
		return r;
	endfunction

	// Unmasked uncorrectable events log; pointer captures only the first one.
	assign unc_log = unc_event & `AER_UNC_IMPL & ~st_ff.unc_msk;

	aer_first_ptr u_first_ptr (
		.events   (unc_log),
		.position (enc_pos),
		.found    (enc_hit)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state: bus phases, sticky flags, logging and messages.
	always_comb begin
		logic        wr_go;
		logic [31:0] cor_log;
		logic [31:0] w1c;
		nxt_st  = st_ff;
		wr_go   = st_ff.phase == aer_pkg::AER_DATA && st_ff.wr;
		w1c     = wr_go ? hwdata : 32'h00000000;
		cor_log = cor_event & `AER_COR_IMPL & ~st_ff.cor_msk;
		nxt_st.m_cor = 1'b0;
		nxt_st.m_nf  = 1'b0;
		nxt_st.m_f   = 1'b0;
		// Address phase taken when selected and the bus is ready.
		if (hsel && hready && htrans[1]) begin
			nxt_st.phase = aer_pkg::AER_DATA;
			nxt_st.wr    = hwrite;
			nxt_st.addr  = haddr;
			nxt_st.rdata = read_reg(st_ff, haddr);
		end else begin
			nxt_st.phase = aer_pkg::AER_IDLE;
		end
		// Software writes to read/write fields.
		if (wr_go) begin
			unique case (st_ff.addr)
				`AER_OFF_UNC_MASK: nxt_st.unc_msk = hwdata & `AER_UNC_IMPL;
				`AER_OFF_UNC_SEV:  nxt_st.sev = hwdata & `AER_UNC_IMPL;
				`AER_OFF_COR_MASK: nxt_st.cor_msk = hwdata & `AER_COR_IMPL;
				`AER_OFF_CAP_CTRL: begin
					nxt_st.gen_en = hwdata[`AER_CAP_GEN_EN];
					nxt_st.chk_en = hwdata[`AER_CAP_CHK_EN];
				end
				`AER_OFF_IRQ_MASK: nxt_st.irq_msk = hwdata[1:0];
				default: ;
			endcase
		end
		// Status flags: a same-cycle event wins over the write-one clear.
		nxt_st.unc_sts = (st_ff.unc_sts & ~((st_ff.addr == `AER_OFF_UNC_STATUS) ? w1c : 32'h0))
			| (unc_event & `AER_UNC_IMPL);
		nxt_st.cor_sts = (st_ff.cor_sts & ~((st_ff.addr == `AER_OFF_COR_STATUS) ? w1c : 32'h0))
			| (cor_event & `AER_COR_IMPL);
		// Pointer is rearmed once software clears the status bit it names.
		if (st_ff.fptr_valid && !nxt_st.unc_sts[st_ff.fptr]) begin
			nxt_st.fptr_valid = 1'b0;
		end
		if (!st_ff.fptr_valid && enc_hit) begin
			nxt_st.fptr       = enc_pos;
			nxt_st.fptr_valid = 1'b1;
			nxt_st.hdr        = hdr_in;
		end
		// Error messages toward the root complex, split by severity.
		if (|(unc_log & st_ff.sev)) begin
			nxt_st.m_f = 1'b1;
		end
		if (|(unc_log & ~st_ff.sev)) begin
			nxt_st.m_nf = 1'b1;
		end
		if (|cor_log) begin
			nxt_st.m_cor = 1'b1;
		end
		// Interrupt status: bit 0 correctable, bit 1 uncorrectable.
		w1c = (st_ff.addr == `AER_OFF_IRQ_STATUS) ? w1c : 32'h00000000;
		nxt_st.irq_sts = (st_ff.irq_sts & ~w1c[1:0]) | {|unc_log, |cor_log};
		nxt_st.irq = |(nxt_st.irq_sts & nxt_st.irq_msk);
	end

	////////////////////////////////////////////////////////////////////////////
	// Register the state; hot reset clears only the non-sticky parts.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff     <= '0;
			st_ff.sev <= `AER_SEV_RESET;
		end else if (hot_reset) begin
			st_ff.phase   <= aer_pkg::AER_IDLE;
			st_ff.irq_sts <= 2'h0;
			st_ff.irq_msk <= 2'h0;
			st_ff.irq     <= 1'b0;
			st_ff.m_cor   <= 1'b0;
			st_ff.m_nf    <= 1'b0;
			st_ff.m_f     <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from flip-flops; hreadyout and hresp are constants.
	assign hrdata       = st_ff.rdata;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign ecrc_gen_en  = st_ff.gen_en;
	assign ecrc_chk_en  = st_ff.chk_en;
	assign msg_cor      = st_ff.m_cor;
	assign msg_nonfatal = st_ff.m_nf;
	assign msg_fatal    = st_ff.m_f;
	assign irq          = st_ff.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the logged and reported behaviour.
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn || hot_reset);

	cor_set_a: assert property (cor_event[0] |=> st_ff.cor_sts[0])
		else $error("receiver error not recorded");
	bad_tlp_a: assert property (cor_event[6] |=> st_ff.cor_sts[6])
		else $error("bad packet not recorded");
	bad_dllp_a: assert property (cor_event[7] |=> st_ff.cor_sts[7])
		else $error("bad link packet not recorded");
	rollover_a: assert property (cor_event[8] |=> st_ff.cor_sts[8])
		else $error("rollover not recorded");
	cor_rsvd_a: assert property (st_ff.cor_sts[31:13] == 19'h0)
		else $error("reserved correctable bit set");
	cor_mask_a: assert property (|(cor_event & st_ff.cor_msk) && !(|(cor_event & ~st_ff.cor_msk & `AER_COR_IMPL)) |=> !msg_cor)
		else $error("masked error sent a message");
	fptr_hold_a: assert property (st_ff.fptr_valid && st_ff.unc_sts[st_ff.fptr] |=> $stable(st_ff.fptr))
		else $error("first pointer changed");
	fatal_msg_a: assert property (|(unc_log & st_ff.sev) |=> msg_fatal)
		else $error("fatal message missing");
	unc_sticky_a: assert property (unc_event[18] |=> st_ff.unc_sts[18])
		else $error("malformed status not set");
	ecrc_en_a: assert property (wr_clear_any() && st_ff.addr == `AER_OFF_CAP_CTRL
		|=> ecrc_gen_en == $past(hwdata[`AER_CAP_GEN_EN]))
		else $error("generation enable mismatch");

	// True in the data phase of a write; shared by the write checks above and below.
	function automatic logic wr_clear_any();
		return st_ff.phase == aer_pkg::AER_DATA && st_ff.wr;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Further checks on severity, masking, pointer and header capture.
	// These watch the registered state, so they fire one cycle after a fault.

	// Check enable follows the written data bit, the cycle after the write.
	// A stuck enable would otherwise only show when packets arrive.
	chk_en_a: assert property (wr_clear_any() && st_ff.addr == `AER_OFF_CAP_CTRL
		|=> ecrc_chk_en == $past(hwdata[`AER_CAP_CHK_EN]))
		else $error("check enable mismatch");

	// Severity holds no bit outside the implemented positions.
	// Software may write ones anywhere, so the write mask must hold.
	sev_rsvd_a: assert property ((st_ff.sev & ~`AER_UNC_IMPL) == 32'h0)
		else $error("reserved severity bit set");

	// An unmasked event of non-fatal severity raises the non-fatal message.
	// The fatal and non-fatal paths are split, so each is checked alone.
	nonfatal_msg_a: assert property (|(unc_log & ~st_ff.sev) |=> msg_nonfatal)
		else $error("non-fatal message missing");

	// Without an unmasked uncorrectable event no such message goes out.
	// This guards against a mask that only gates the status.
	unc_quiet_a: assert property (unc_log == 32'h0 |=> !msg_fatal && !msg_nonfatal)
		else $error("uncorrectable message without event");

	// An unmasked correctable event raises the correctable message.
	// Together with the masked check this pins the mask both ways.
	cor_msg_a: assert property (|(cor_event & `AER_COR_IMPL & ~st_ff.cor_msk) |=> msg_cor)
		else $error("correctable message missing");

	// Replay timeout is recorded in correctable bit 12.
	// It is the highest implemented correctable position.
	timeout_a: assert property (cor_event[12] |=> st_ff.cor_sts[12])
		else $error("replay timeout not recorded");

	// A set receiver error bit stays set unless software writes a one to it.
	// Hot reset is excluded by the default disable, as it keeps the bit too.
	cor_sticky_a: assert property (st_ff.cor_sts[0] && !(wr_clear_any()
		&& st_ff.addr == `AER_OFF_COR_STATUS && hwdata[0]) |=> st_ff.cor_sts[0])
		else $error("receiver error bit lost");

	// Writing a one clears an uncorrectable bit when no new event arrives.
	// A same-cycle event wins, so that case is left out of the antecedent.
	unc_clear_a: assert property (wr_clear_any() && st_ff.addr == `AER_OFF_UNC_STATUS
		&& hwdata[18] && !unc_event[18] |=> !st_ff.unc_sts[18])
		else $error("malformed status not cleared");

	// Uncorrectable status holds no bit outside the implemented positions.
	// Event inputs may carry stray bits, so the input mask must hold.
	unc_rsvd_a: assert property ((st_ff.unc_sts & ~`AER_UNC_IMPL) == 32'h0)
		else $error("reserved uncorrectable bit set");

	// When the pointer is free, the next logged error loads its position.
	// The encoder picks the lowest position when several arrive at once.
	fptr_load_a: assert property (!st_ff.fptr_valid && enc_hit
		|=> st_ff.fptr == $past(enc_pos))
		else $error("first pointer not loaded");

	// The header log is captured together with the pointer.
	// Loading it at any other time would overwrite the first failure.
	hdr_load_a: assert property (!st_ff.fptr_valid && enc_hit
		|=> st_ff.hdr == $past(hdr_in))
		else $error("header not captured");

	// A read of the control register returns both capability bits.
	// The read data are formed at the address phase and stand afterwards.
	cap_read_a: assert property (hsel && hready && htrans[1]
		&& haddr == `AER_OFF_CAP_CTRL |=> hrdata[`AER_CAP_GEN_CAP] && hrdata[`AER_CAP_CHK_CAP])
		else $error("capability bits not read as one");

	////////////////////////////////////////////////////////////////////////////
	// Coverage of the main scenarios.
	cor_cov_c: cover property (cor_event[0] ##1 st_ff.cor_sts[0]);
	fatal_cov_c: cover property (msg_fatal);
	irq_cov_c: cover property (irq);
	// A second error while the pointer is held: it must not move.
	held_cov_c: cover property (st_ff.fptr_valid && enc_hit);
	// A non-fatal message, from an unmasked event whose severity bit is clear.
	nonfatal_cov_c: cover property (msg_nonfatal);
endmodule

// ==== testbench/aer_link_model.sv ====
// Link-side model: raises error events with a packet header and counts messages.
// Assumes the bench calls fire just after a rising edge of hclk.
`timescale 1ns/1ps
module aer_link_model (
	// Clock.
	input  wire logic         hclk,
	// Events and header toward the bank.
	output logic      [31:0]  unc_event,
	output logic      [31:0]  cor_event,
	output logic      [127:0] hdr_in,
	// Messages toward the root complex.
	input  wire logic         msg_cor,
	input  wire logic         msg_nonfatal,
	input  wire logic         msg_fatal
);
	////////////////////////////////////////////////////////////////////////
	int n_cor = 0; // Correctable messages seen.
	int n_nf  = 0; // Non-fatal messages seen.
	int n_fat = 0; // Fatal messages seen.
	initial begin
		unc_event = '0;
		cor_event = '0;
		hdr_in    = '0;
	end
	// One-cycle pulse; the header is inverted afterwards so a late sample shows.
	task automatic fire(input logic [31:0] u, input logic [31:0] c, input logic [127:0] h);
		unc_event <= u;
		cor_event <= c;
		hdr_in    <= h;
		@(posedge hclk);
		unc_event <= '0;
		cor_event <= '0;
		hdr_in    <= ~h;
		repeat (3) @(posedge hclk);
	endtask
	// Messages are single-cycle pulses, so each high cycle is one message.
	always @(posedge hclk) begin
		if (msg_cor === 1'b1) n_cor++;
		if (msg_nonfatal === 1'b1) n_nf++;
		if (msg_fatal === 1'b1) n_fat++;
	end
endmodule

// ==== testbench/tb_top.sv ====
// Bench for the error reporting bank: AHB-Lite master tasks and directed checks.
// Assumes a zero-wait slave whose hreadyout is the bus's hready.
`timescale 1ns/1ps
`include "aer_params.svh"
module tb_top;
	logic         hclk = 1'b0;    // Bus clock, 125 MHz.
	logic         hresetn = 1'b0; // Cold reset, active low.
	logic         hot_reset = 1'b0;
	logic         hsel = 1'b0;
	logic [11:0]  haddr = '0;
	logic [1:0]   htrans = '0;
	logic         hwrite = 1'b0;
	logic [31:0]  hwdata = '0;
	logic [31:0]  hrdata, unc_ev, cor_ev;
	logic         hreadyout, hresp, gen_en, chk_en, m_cor, m_nf, m_fat, irq;
	logic [127:0] hdr;
	int           miscompares = 0;
	int           checks = 0;
	logic [127:0] h1 = 128'h00112233_44556677_8899AABB_CCDDEEFF;
	always #4 hclk = ~hclk;
	aer_regs aer_regs_inst (.hclk(hclk), .hresetn(hresetn), .hot_reset(hot_reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .unc_event(unc_ev), .cor_event(cor_ev), .hdr_in(hdr),
		.ecrc_gen_en(gen_en), .ecrc_chk_en(chk_en), .msg_cor(m_cor),
		.msg_nonfatal(m_nf), .msg_fatal(m_fat), .irq(irq));
	aer_link_model aer_link_model_inst (.hclk(hclk), .unc_event(unc_ev),
		.cor_event(cor_ev), .hdr_in(hdr), .msg_cor(m_cor), .msg_nonfatal(m_nf),
		.msg_fatal(m_fat));
	////////////////////////////////////////////////////////////////////////
	// Prints the verdict and ends the run.
	task automatic stop_test;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask
	// Waits for hready high at a rising edge, bounded so a hang ends the run.
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			stop_test();
		end
	endtask
	// One single word transfer; read data are taken at the closing edge.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence: reset values, events, masking, resets.
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(`AER_OFF_UNC_SEV, `AER_SEV_RESET);
		rc(`AER_OFF_COR_STATUS, 32'h0);
		rc(`AER_OFF_COR_MASK, 32'h0);
		rc(`AER_OFF_CAP_CTRL, 32'h000000A0);
		rc(12'h200, 32'h0);
		wr(`AER_OFF_UNC_SEV, 32'hFFFFFFFF);
		rc(`AER_OFF_UNC_SEV, `AER_UNC_IMPL);
		wr(`AER_OFF_UNC_SEV, `AER_SEV_RESET);
		wr(`AER_OFF_IRQ_MASK, 32'h1);
		// Each correctable cause sets, interrupts, messages and clears alone.
		for (int i = 0; i < 5; i++) begin
			int b;
			b = (i == 0) ? 0 : (i == 1) ? 6 : (i == 2) ? 7 : (i == 3) ? 8 : 12;
			aer_link_model_inst.fire(32'h0, 32'h1 << b, h1);
			rc(`AER_OFF_COR_STATUS, 32'h1 << b);
			chk(aer_link_model_inst.n_cor, i + 1);
			chk({31'h0, irq}, 32'h1);
			wr(`AER_OFF_COR_STATUS, 32'hFFFFFFFF);
			wr(`AER_OFF_IRQ_STATUS, 32'h1);
			rc(`AER_OFF_COR_STATUS, 32'h0);
			chk({31'h0, irq}, 32'h0);
		end
		// A masked cause sends no message.
		wr(`AER_OFF_COR_MASK, 32'hFFFFFFFF);
		rc(`AER_OFF_COR_MASK, `AER_COR_IMPL);
		aer_link_model_inst.fire(32'h0, 32'h1, h1);
		chk(aer_link_model_inst.n_cor, 5);
		wr(`AER_OFF_COR_MASK, 32'h0);
		wr(`AER_OFF_CAP_CTRL, 32'hFFFFFFFF);
		rc(`AER_OFF_CAP_CTRL, 32'h000001E0);
		chk({30'h0, gen_en, chk_en}, 32'h3);
		// First uncorrectable error: pointer, header and fatal message.
		wr(`AER_OFF_IRQ_MASK, 32'h2);
		aer_link_model_inst.fire(32'h10, 32'h0, h1);
		rc(`AER_OFF_UNC_STATUS, 32'h10);
		rc(`AER_OFF_CAP_CTRL, 32'h000001E4);
		for (int k = 0; k < 4; k++) rc(`AER_OFF_HDR_LOG0 + 12'(4 * k), h1[127 - 32 * k -: 32]);
		chk(aer_link_model_inst.n_fat, 1);
		chk({31'h0, irq}, 32'h1);
		aer_link_model_inst.fire(32'h1000, 32'h0, ~h1);
		chk(aer_link_model_inst.n_nf, 1);
		rc(`AER_OFF_CAP_CTRL, 32'h000001E4);
		rc(`AER_OFF_HDR_LOG0, h1[127:96]);
		// Hot reset keeps sticky state; cold reset restores it.
		hot_reset <= 1'b1;
		@(posedge hclk);
		hot_reset <= 1'b0;
		@(posedge hclk);
		rc(`AER_OFF_CAP_CTRL, 32'h000001E4);
		rc(`AER_OFF_UNC_STATUS, 32'h1010);
		chk({31'h0, irq}, 32'h0);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(`AER_OFF_CAP_CTRL, 32'h000000A0);
		stop_test();
	end
endmodule
